/* File: hdl/srws_pkg.sv */
// shared constants for the supply reset watchdog supervisor
package srws_pkg;
   // timing limits in nanoseconds
   localparam int unsigned CLOCK_PERIOD_NSEC   = 10;
   localparam int unsigned RESET_LOW_MAX_NSEC  = 2000;
   localparam int unsigned TRIGGER_MIN_NSEC    = 10000;
   // longest time rounds down, never below one cycle
   localparam int unsigned RESET_LOW_CYCLES    = (RESET_LOW_MAX_NSEC / CLOCK_PERIOD_NSEC) < 1 ? 1
                                                 : (RESET_LOW_MAX_NSEC / CLOCK_PERIOD_NSEC);
   // least trigger width rounds up
   localparam int unsigned TRIGGER_MIN_CYCLES  = (TRIGGER_MIN_NSEC + CLOCK_PERIOD_NSEC - 1) / CLOCK_PERIOD_NSEC;
   // timer ramp levels abstracted as counts (start level 0.9V maps to zero)
   localparam int unsigned DELAY_END_COUNT     = 5000000;  // about 50 ms at 100 MHz
   localparam int unsigned WD_FAST_COUNT       = 16;       // fast pre-charge to start level
   localparam int unsigned WD_END_COUNT        = 10000000; // watchdog interval
   localparam int unsigned TIMER_WIDTH         = 32;
   // reset values
   localparam logic        RESET_OUT_RST       = 1'b0;
   localparam logic        ENABLE_OUT_RST      = 1'b0;
endpackage

/* File: hdl/srws_sync.sv */
// two flip-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/1ps
`default_nettype none
module srws_sync #(
   parameter int unsigned WIDTH = 1
) (
   input  wire logic             clock,
   input  wire logic             resetn,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // first stage is read only by the second
   always_comb begin
      meta_d = async_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule
`default_nettype wire

/* File: hdl/srws_supervisor.sv */
// supervisor: supply window reset, delay timer, watchdog, enable logic
`timescale 1ns/1ps
`default_nettype none
module srws_supervisor #(
   parameter int unsigned DELAY_END = srws_pkg::DELAY_END_COUNT,
   parameter int unsigned WD_FAST   = srws_pkg::WD_FAST_COUNT,
   parameter int unsigned WD_END    = srws_pkg::WD_END_COUNT
) (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic below_high_thr,    // supply below the strap-low threshold
   input  wire logic below_low_thr,     // supply below the strap-open threshold
   input  wire logic supply_high_compare,
   input  wire logic thr_strap_open,    // strap open selects lower threshold
   input  wire logic watchdog_disable,
   input  wire logic watchdog_trigger,
   input  wire logic ignition_above_on, // ignition above turn-on level
   input  wire logic ignition_above_off,// ignition above turn-off level
   input  wire logic keep_alive,
   output var  logic system_reset_n,
   output var  logic regulator_enable
);
   localparam int unsigned TW = srws_pkg::TIMER_WIDTH;
   localparam logic [TW-1:0] DEND  = TW'(DELAY_END);
   localparam logic [TW-1:0] WFAST = TW'(WD_FAST);
   localparam logic [TW-1:0] WEND  = TW'(WD_END);

   typedef enum logic [2:0] {
      SRWS_WD_HOLD = 3'h1,
      SRWS_WD_FAST = 3'h2,
      SRWS_WD_RUN  = 3'h4
   } srws_wd_t;

   logic [7:0] sync_v;
   logic       blh_s, bll_s, shi_s, strap_s, wdd_s, trig_s, ign_on_s, ign_off_s;
   logic       trig_prev_q, trig_prev_d;

   // all loose pins cross into the clock domain first
   srws_sync #(.WIDTH(8)) u_sync (
      .clock    (clock),
      .resetn   (resetn),
      .async_in ({below_high_thr, below_low_thr, supply_high_compare, thr_strap_open,
                  watchdog_disable, watchdog_trigger, ignition_above_on, ignition_above_off}),
      .sync_out (sync_v)
   );
   assign {blh_s, bll_s, shi_s, strap_s, wdd_s, trig_s, ign_on_s, ign_off_s} = sync_v;

   logic supply_low_compare;
   logic out_of_reg;
   logic trig_rise;
   // threshold select, window compare and trigger edge found after sync
   always_comb begin
      supply_low_compare = strap_s ? bll_s : blh_s;
      out_of_reg         = supply_low_compare | shi_s;
      trig_rise          = trig_s & ~trig_prev_q;
      trig_prev_d        = trig_s;
   end

   logic [TW-1:0] reset_delay_timer_q, reset_delay_timer_d;
   logic          delay_clear_q, delay_clear_d;
   logic          reset_n_q, reset_n_d;
   logic [TW-1:0] wd_cnt_q, wd_cnt_d;
   srws_wd_t      wd_state_q, wd_state_d;
   logic          wd_expire;
   logic          en_q, en_d, ign_q, ign_d;
   logic          ka_meta_q, ka_q;

   // delay timer and reset output; one clear clears the whole count, so the next
   // interval always starts from zero and all intervals match
   always_comb begin
      reset_delay_timer_d = reset_delay_timer_q;
      delay_clear_d       = delay_clear_q;
      reset_n_d           = reset_n_q;
      if (out_of_reg || wd_expire) begin
         delay_clear_d       = 1'b1;
         reset_delay_timer_d = '0;
         reset_n_d           = 1'b0;
      end else if (delay_clear_q) begin
         delay_clear_d       = 1'b0;
         reset_delay_timer_d = '0;
      end else if (!reset_n_q) begin
         if (reset_delay_timer_q >= DEND - 1'b1) begin
            reset_n_d = 1'b1;
         end else begin
            reset_delay_timer_d = reset_delay_timer_q + 1'b1;
         end
      end
   end

   // watchdog: held in reset, fast charge, slow run, expire or refresh
   always_comb begin
      wd_state_d = wd_state_q;
      wd_cnt_d   = wd_cnt_q;
      wd_expire  = 1'b0;
      unique case (wd_state_q)
         SRWS_WD_HOLD: begin
            wd_cnt_d = '0;
            if (reset_n_q && !wdd_s) begin
               wd_state_d = SRWS_WD_FAST;
            end
         end
         SRWS_WD_FAST: begin
            wd_cnt_d = wd_cnt_q + 1'b1;
            if (wd_cnt_q >= WFAST - 1'b1) begin
               wd_cnt_d   = '0;
               wd_state_d = SRWS_WD_RUN;
            end
         end
         SRWS_WD_RUN: begin
            wd_cnt_d = wd_cnt_q + 1'b1;
            if (trig_rise) begin
               wd_cnt_d = '0; // one-shot clears to start level
            end else if (wd_cnt_q >= WEND - 1'b1) begin
               wd_expire  = 1'b1;
               wd_cnt_d   = '0;
            end
         end
         default: begin
            wd_state_d = SRWS_WD_HOLD;
            wd_cnt_d   = '0;
         end
      endcase
      if (!reset_n_q || wdd_s) begin
         wd_state_d = SRWS_WD_HOLD;
         wd_cnt_d   = '0;
      end
   end

   // ignition hysteresis and keep-alive OR
   always_comb begin
      ign_d = ign_q;
      if (ign_on_s) begin
         ign_d = 1'b1;
      end else if (!ign_off_s) begin
         ign_d = 1'b0;
      end
      en_d = ign_q | ka_q;
   end

   // keep-alive synchroniser, kept apart so its first stage feeds only the second
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         ka_meta_q <= 1'b0;
         ka_q      <= 1'b0;
      end else begin
         ka_meta_q <= keep_alive;
         ka_q      <= ka_meta_q;
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         reset_delay_timer_q <= '0;
         delay_clear_q       <= 1'b1;
         reset_n_q           <= srws_pkg::RESET_OUT_RST; // asserted at power-up
         wd_cnt_q            <= '0;
         wd_state_q          <= SRWS_WD_HOLD;
         trig_prev_q         <= 1'b0;
         ign_q               <= 1'b0;
         en_q                <= srws_pkg::ENABLE_OUT_RST;
      end else begin
         reset_delay_timer_q <= reset_delay_timer_d;
         delay_clear_q       <= delay_clear_d;
         reset_n_q           <= reset_n_d;
         wd_cnt_q            <= wd_cnt_d;
         wd_state_q          <= wd_state_d;
         trig_prev_q         <= trig_prev_d;
         ign_q               <= ign_d;
         en_q                <= en_d;
      end
   end

   assign system_reset_n   = reset_n_q;
   assign regulator_enable = en_q;

   // assertions
   a_reset_on_window: assert property (@(posedge clock) disable iff (!resetn)
      out_of_reg |=> !reset_n_q) else $error("reset not low after window loss");
   a_delay_held_low: assert property (@(posedge clock) disable iff (!resetn)
      $rose(reset_n_q) |-> $past(reset_delay_timer_q) >= DEND - 1'b1)
      else $error("reset released before delay end");
   a_wd_held_reset: assert property (@(posedge clock) disable iff (!resetn)
      !reset_n_q |=> wd_state_q == SRWS_WD_HOLD && wd_cnt_q == '0)
      else $error("watchdog counts during reset");
   a_wd_expire_reset: assert property (@(posedge clock) disable iff (!resetn)
      wd_expire |=> !reset_n_q && delay_clear_q) else $error("expiry gave no reset");
   a_wd_disabled: assert property (@(posedge clock) disable iff (!resetn)
      wdd_s |=> wd_state_q == SRWS_WD_HOLD) else $error("watchdog runs while disabled");
   a_trig_refresh: assert property (@(posedge clock) disable iff (!resetn)
      trig_rise && wd_state_q == SRWS_WD_RUN && reset_n_q && !wdd_s && !out_of_reg
      |=> wd_cnt_q == '0) else $error("trigger did not refresh");
   a_enable_or: assert property (@(posedge clock) disable iff (!resetn)
      ##1 en_q == ($past(ign_q) | $past(ka_q))) else $error("enable not OR of inputs");
   a_ign_hyst: assert property (@(posedge clock) disable iff (!resetn)
      ign_on_s |=> ign_q) else $error("ignition did not switch on");
   a_delay_latch: assert property (@(posedge clock) disable iff (!resetn)
      delay_clear_q && !out_of_reg && !wd_expire |=> reset_delay_timer_q == '0)
      else $error("delay left start before clear done");
   c_power_up: cover property (@(posedge clock) disable iff (!resetn) $rose(reset_n_q));
   c_wd_expire: cover property (@(posedge clock) disable iff (!resetn) wd_expire);
   c_keep_alive: cover property (@(posedge clock) disable iff (!resetn) ka_q && !ign_q && en_q);
endmodule
`default_nettype wire

/* File: test/srws_ctrl_model.sv */
// controller model: watchdog trigger pulses and keep-alive level
`timescale 1ns/1ps
`default_nettype none
module srws_ctrl_model #(
   parameter int unsigned HIGH_CYC = srws_pkg::TRIGGER_MIN_CYCLES,
   parameter int unsigned LOW_CYC  = 500
) (
   input  wire logic       clock,
   input  wire logic       system_reset_n,
   input  wire logic [1:0] mode,
   input  wire logic       keep_req,
   output var  logic       watchdog_trigger,
   output var  logic       keep_alive
);
   int unsigned cnt = 0;
   // mode 0 quiet, 1 periodic, 2 stuck high; a short wait after release skips the fast phase
   always @(posedge clock) begin
      keep_alive <= keep_req;
      if (mode == 2'd2) begin
         watchdog_trigger <= 1'b1;
      end else if (mode == 2'd0 || !system_reset_n) begin
         cnt <= 0;
         watchdog_trigger <= 1'b0;
      end else begin
         cnt <= cnt + 1;
         watchdog_trigger <= (cnt >= 50) && (((cnt - 50) % (HIGH_CYC + LOW_CYC)) < HIGH_CYC);
      end
   end
endmodule
`default_nettype wire

/* File: test/srws_supervisor_test.sv */
// self-checking bench for the supply reset watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; $display("BAD %0t got %0h want %0h", $time, (a), (b)); end end
module srws_supervisor_test;
   localparam int DLY = 200;
   localparam int WFAST = 4;
   localparam int WEND = 3000;
   localparam int SLACK = 12;
   logic       clock = 1'b0;
   logic       resetn = 1'b0;
   logic [3:0] sup = 4'b0000;   // below_high, below_low, high_compare, strap_open
   logic       wd_dis = 1'b0;
   logic       ign_on = 1'b1;
   logic       ign_off = 1'b1;
   logic       keep_req = 1'b0;
   logic [1:0] mode = 2'd1;
   logic       trig, keep, system_reset_n, regulator_enable;
   logic       ign_q = 1'b1;   // bench model of the ignition hysteresis
   logic [31:0] rng = 32'hE87A;
   logic [3:0] bad_tab [4] = '{4'b1000, 4'b1101, 4'b0010, 4'b0011};
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   int n;
   srws_supervisor #(.DELAY_END(DLY), .WD_FAST(WFAST), .WD_END(WEND)) DUT (
      .clock(clock), .resetn(resetn), .below_high_thr(sup[3]), .below_low_thr(sup[2]),
      .supply_high_compare(sup[1]), .thr_strap_open(sup[0]), .watchdog_disable(wd_dis),
      .watchdog_trigger(trig), .ignition_above_on(ign_on), .ignition_above_off(ign_off),
      .keep_alive(keep), .system_reset_n(system_reset_n), .regulator_enable(regulator_enable));
   srws_ctrl_model CTRL (.clock(clock), .system_reset_n(system_reset_n), .mode(mode),
      .keep_req(keep_req), .watchdog_trigger(trig), .keep_alive(keep));
   always #5 clock = ~clock;
   // cut a hang short
   always @(posedge clock) begin
      cycles++;
      if (cycles == 50000) begin
         fail_count++;
         $display("BAD %0t timeout", $time);
         close_out();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   // cycles until reset reaches a level, -1 if it never does
   task automatic wait_lvl(input logic lvl, input int lim, output int k);
      k = 0;
      while (system_reset_n !== lvl && k < lim) begin
         @(negedge clock);
         k++;
      end
      if (system_reset_n !== lvl) k = -1;
   endtask
   task automatic in_range(input int k, input int lo, input int hi);
      `CHK((k >= lo) && (k <= hi), 1'b1)
   endtask
   task automatic set_sup(input logic [3:0] v);
      @(posedge clock);
      sup <= v;
   endtask
   task automatic close_out();
      $display("checked %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge clock);
      `CHK(system_reset_n, 1'b0)
      resetn <= 1'b1;
      wait_lvl(1'b1, DLY + 100, n);
      in_range(n, DLY, DLY + SLACK);
      `CHK(regulator_enable, 1'b1)
      $display("power-up test done");
      // each out-of-window case, then full delay back
      foreach (bad_tab[i]) begin
         set_sup(bad_tab[i]);
         wait_lvl(1'b0, 20, n);
         in_range(n, 0, 8);
         set_sup(4'b0000);
         wait_lvl(1'b1, DLY + 100, n);
         in_range(n, DLY, DLY + SLACK);
      end
      set_sup(4'b1001);
      wait_lvl(1'b0, 50, n);
      `CHK(n, -1)
      set_sup(4'b1000);
      wait_lvl(1'b0, 20, n);
      set_sup(4'b0000);
      repeat (DLY / 2) @(posedge clock);
      set_sup(4'b0010);
      repeat (5) @(posedge clock);
      set_sup(4'b0000);
      wait_lvl(1'b1, DLY + 100, n);
      in_range(n, DLY, DLY + SLACK);
      $display("window test done");
      wait_lvl(1'b0, 3 * WEND, n);
      `CHK(n, -1)
      mode <= 2'd0;
      wait_lvl(1'b0, WEND + 2000, n);
      `CHK(n >= 0, 1'b1)
      wait_lvl(1'b1, DLY + 100, n);
      in_range(n, DLY, DLY + SLACK);
      wait_lvl(1'b0, WEND + 200, n);
      in_range(n, WEND + WFAST, WEND + WFAST + SLACK);
      mode <= 2'd2;
      wait_lvl(1'b1, DLY + 100, n);
      wait_lvl(1'b0, WEND + 200, n);
      in_range(n, WEND + WFAST, WEND + WFAST + SLACK);
      mode <= 2'd1;
      wait_lvl(1'b1, DLY + 100, n);
      @(posedge clock);
      wd_dis <= 1'b1;
      mode <= 2'd0;
      wait_lvl(1'b0, 2 * WEND, n);
      `CHK(n, -1)
      $display("watchdog test done");
      // random ignition and keep-alive levels against the hysteresis model
      repeat (40) begin
         rng = xs(rng);
         @(posedge clock);
         ign_on <= rng[0];
         ign_off <= rng[0] | rng[1];
         keep_req <= rng[2];
         if (rng[0]) ign_q = 1'b1;
         else if (!rng[1]) ign_q = 1'b0;
         repeat (8) @(negedge clock);
         `CHK(regulator_enable, ign_q | rng[2])
      end
      $display("enable test done");
      close_out();
   end
endmodule
`default_nettype wire
